/* hw/stc_defines.svh */
// register offsets, field positions and reset values of the threshold bank
`ifndef STC_DEFINES_SVH
`define STC_DEFINES_SVH

`define STC_ADDR_W 7
`define STC_DATA_W 8
`define STC_CODE_W 12

// register offsets within the page
`define STC_OFF_FIRST_AUXILIARY_INPUT_MIN_LO 7'h19
`define STC_OFF_SECOND_AUXILIARY_INPUT_MAX_HI 7'h1A
`define STC_OFF_SECOND_AUXILIARY_INPUT_MAX_LO 7'h1B
`define STC_OFF_SECOND_AUXILIARY_INPUT_MIN_HI 7'h1C
`define STC_OFF_SECOND_AUXILIARY_INPUT_MIN_LO 7'h1D
`define STC_OFF_TEMP_MAX_HI 7'h1E
`define STC_OFF_TEMP_MAX_LO 7'h1F
`define STC_OFF_TEMP_MIN_HI 7'h20
`define STC_OFF_TEMP_MIN_LO 7'h21
`define STC_OFF_RSVD_FIRST 7'h22
`define STC_OFF_RSVD_LAST 7'h29
`define STC_OFF_X_HI 7'h2A
`define STC_OFF_X_LO 7'h2B
`define STC_OFF_Y_HI 7'h2C
`define STC_OFF_Y_LO 7'h2D

// threshold bank: eight bytes from the first high register onward
`define STC_THR_COUNT 8
`define STC_THR_IDX_W 3

// index of each threshold byte inside the bank
`define STC_IDX_SECOND_AUXILIARY_INPUT_MAX_HI 3'h0
`define STC_IDX_SECOND_AUXILIARY_INPUT_MAX_LO 3'h1
`define STC_IDX_SECOND_AUXILIARY_INPUT_MIN_HI 3'h2
`define STC_IDX_SECOND_AUXILIARY_INPUT_MIN_LO 3'h3
`define STC_IDX_TEMP_MAX_HI 3'h4
`define STC_IDX_TEMP_MAX_LO 3'h5
`define STC_IDX_TEMP_MIN_HI 3'h6
`define STC_IDX_TEMP_MIN_LO 3'h7

// field positions in a high register
`define STC_EN_BIT 4
`define STC_HI_NIB_MSB 3
`define STC_HI_NIB_LSB 0

// flag positions in the flag vector
`define STC_FLAG_TEMP_MIN 0
`define STC_FLAG_TEMP_MAX 1
`define STC_FLAG_SECOND_AUXILIARY_INPUT_MIN 2
`define STC_FLAG_SECOND_AUXILIARY_INPUT_MAX 3
`define STC_FLAG_W 4

// reset and read-back values
`define STC_REG_RESET 8'h00
`define STC_RSVD_READ 8'h00
`define STC_UNMAPPED_READ 8'h00

`endif

/* hw/stc_pkg.sv */
// types shared by the threshold and coordinate register bank
`default_nettype none
package stc_pkg;

  // source of a conversion result, one-hot
  typedef enum logic [2:0] {
    STC_SRC_SECOND_AUXILIARY_INPUT = 3'h1,
    STC_SRC_TEMPERATURE_METHOD_ONE = 3'h2,
    STC_SRC_TEMPERATURE_METHOD_TWO = 3'h4
  } stc_src_e;

  // one conversion result strobe
  typedef struct packed {
    logic valid;
    stc_src_e src;
    logic [11:0] code;
  } stc_result_s;

  // one coordinate pair strobe
  typedef struct packed {
    logic valid;
    logic [11:0] x;
    logic [11:0] y;
  } stc_coord_s;

  // register access request from the serial control port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } stc_req_s;

endpackage : stc_pkg
`default_nettype wire

/* hw/stc_thresh_check.sv */
// one enabled threshold comparison against a 12-bit conversion result
`include "stc_defines.svh"
`default_nettype none
module stc_thresh_check #(
  parameter int CODE_W = `STC_CODE_W,
  parameter bit IS_MAX = 1'b1
) (
  input wire logic [7:0] hi_in,
  input wire logic [7:0] lo_in,
  input wire logic result_ok_in,
  input wire logic [CODE_W-1:0] code_in,
  output logic hit_out
);

  logic [CODE_W-1:0] thr;
  logic enabled;

  // threshold is the high nibble above the low byte, unsigned
  assign thr = {hi_in[`STC_HI_NIB_MSB:`STC_HI_NIB_LSB], lo_in};
  assign enabled = hi_in[`STC_EN_BIT];

  // disabled checks never fire, whatever the scan mode
  always_comb begin
    if (!enabled || !result_ok_in) begin
      hit_out = 1'b0;
    end else if (IS_MAX) begin
      hit_out = (code_in >= thr);
    end else begin
      hit_out = (code_in <= thr);
    end
  end

endmodule : stc_thresh_check
`default_nettype wire

/* hw/stc_regs.sv */
// threshold, enable and coordinate register bank of the sar subsystem
//
// Notes on behaviour
// - second auxiliary maximum check runs only while its enable bit is set.
// - second auxiliary maximum threshold is high nibble above the low byte.
// - second auxiliary minimum check runs only while its enable bit is set.
// - second auxiliary minimum threshold is high nibble above the low byte.
// - temperature maximum check, both methods, runs only while enabled.
// - temperature maximum threshold is high nibble above the low byte.
// - temperature minimum check, both methods, runs only while enabled.
// - temperature minimum threshold is high nibble above the low byte.
// - first auxiliary minimum low byte is read/write and resets to zero.
// - x high register returns upper x byte, read-only, resets zero.
// - x low register returns lower x byte, read-only, resets zero.
// - y high register returns upper y byte, read-only, resets zero.
// - maximum flag on result at or above, minimum on at or below.
// - flags are sticky, cleared by reading, set again on recurrence.
// - y low byte is readable at the register after y high.
`include "stc_defines.svh"
`default_nettype none
module stc_regs #(
  parameter int CODE_W = `STC_CODE_W
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire stc_pkg::stc_req_s req_in,
  input wire stc_pkg::stc_result_s result_in,
  input wire stc_pkg::stc_coord_s coord_in,
  input wire logic flag_read_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic [`STC_FLAG_W-1:0] flags_out,
  output logic [7:0] first_auxiliary_input_min_low_out
);

  // threshold bank, addressed by index
  logic [7:0] thr_q [`STC_THR_COUNT];
  logic [7:0] first_auxiliary_input_min_lo_q;
  logic [CODE_W-1:0] x_q;
  logic [CODE_W-1:0] y_q;
  logic [`STC_FLAG_W-1:0] flags_q;
  logic [`STC_FLAG_W-1:0] flags_d;
  logic [`STC_FLAG_W-1:0] hit;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic in_bank;
  logic in_rsvd;
  logic [`STC_THR_IDX_W-1:0] bank_idx;
  logic is_second_auxiliary_input;
  logic is_temp;

  // address decode of the threshold bank and the reserved hole
  assign in_bank = (req_in.addr >= `STC_OFF_SECOND_AUXILIARY_INPUT_MAX_HI) &&
                   (req_in.addr <= `STC_OFF_TEMP_MIN_LO);
  assign in_rsvd = (req_in.addr >= `STC_OFF_RSVD_FIRST) &&
                   (req_in.addr <= `STC_OFF_RSVD_LAST);
  assign bank_idx = 3'(req_in.addr - `STC_OFF_SECOND_AUXILIARY_INPUT_MAX_HI);

  // which comparison pair a result feeds; both temperature methods share
  assign is_second_auxiliary_input = result_in.valid &&
                   (result_in.src == stc_pkg::STC_SRC_SECOND_AUXILIARY_INPUT);
  assign is_temp = result_in.valid &&
                   ((result_in.src == stc_pkg::STC_SRC_TEMPERATURE_METHOD_ONE) ||
                    (result_in.src == stc_pkg::STC_SRC_TEMPERATURE_METHOD_TWO));

  // threshold bank writes; upper bits are stored as written, so a
  // host that ignores the zero-write advice reads its own value back
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < `STC_THR_COUNT; i++) begin
        thr_q[i] <= `STC_REG_RESET;
      end
    end else if (req_in.wr && in_bank) begin
      thr_q[bank_idx] <= req_in.wdata;
    end
  end

  // first auxiliary minimum low byte
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      first_auxiliary_input_min_lo_q <= `STC_REG_RESET;
    end else if (req_in.wr && (req_in.addr == `STC_OFF_FIRST_AUXILIARY_INPUT_MIN_LO)) begin
      first_auxiliary_input_min_lo_q <= req_in.wdata;
    end
  end

  assign first_auxiliary_input_min_low_out = first_auxiliary_input_min_lo_q;

  // coordinates captured as a pair so high and low never tear
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      x_q <= '0;
      y_q <= '0;
    end else if (coord_in.valid) begin
      x_q <= coord_in.x;
      y_q <= coord_in.y;
    end
  end

  // the four comparators
  stc_thresh_check #(
    .CODE_W(CODE_W),
    .IS_MAX(1'b1)
  ) u_second_auxiliary_input_max (
    .hi_in(thr_q[`STC_IDX_SECOND_AUXILIARY_INPUT_MAX_HI]),
    .lo_in(thr_q[`STC_IDX_SECOND_AUXILIARY_INPUT_MAX_LO]),
    .result_ok_in(is_second_auxiliary_input),
    .code_in(result_in.code),
    .hit_out(hit[`STC_FLAG_SECOND_AUXILIARY_INPUT_MAX])
  );

  stc_thresh_check #(
    .CODE_W(CODE_W),
    .IS_MAX(1'b0)
  ) u_second_auxiliary_input_min (
    .hi_in(thr_q[`STC_IDX_SECOND_AUXILIARY_INPUT_MIN_HI]),
    .lo_in(thr_q[`STC_IDX_SECOND_AUXILIARY_INPUT_MIN_LO]),
    .result_ok_in(is_second_auxiliary_input),
    .code_in(result_in.code),
    .hit_out(hit[`STC_FLAG_SECOND_AUXILIARY_INPUT_MIN])
  );

  stc_thresh_check #(
    .CODE_W(CODE_W),
    .IS_MAX(1'b1)
  ) u_temp_max (
    .hi_in(thr_q[`STC_IDX_TEMP_MAX_HI]),
    .lo_in(thr_q[`STC_IDX_TEMP_MAX_LO]),
    .result_ok_in(is_temp),
    .code_in(result_in.code),
    .hit_out(hit[`STC_FLAG_TEMP_MAX])
  );

  stc_thresh_check #(
    .CODE_W(CODE_W),
    .IS_MAX(1'b0)
  ) u_temp_min (
    .hi_in(thr_q[`STC_IDX_TEMP_MIN_HI]),
    .lo_in(thr_q[`STC_IDX_TEMP_MIN_LO]),
    .result_ok_in(is_temp),
    .code_in(result_in.code),
    .hit_out(hit[`STC_FLAG_TEMP_MIN])
  );

  // sticky flags: a hit in the clearing cycle survives the clear
  always_comb begin
    flags_d = flags_q;
    if (flag_read_in) begin
      flags_d = '0;
    end
    flags_d = flags_d | hit;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_out = flags_q;

  // read mux; reserved and unmapped offsets read as zero
  always_comb begin
    rdata_d = `STC_UNMAPPED_READ;
    if (in_bank) begin
      rdata_d = thr_q[bank_idx];
    end else if (in_rsvd) begin
      rdata_d = `STC_RSVD_READ;
    end else begin
      case (req_in.addr)
        `STC_OFF_FIRST_AUXILIARY_INPUT_MIN_LO: rdata_d = first_auxiliary_input_min_lo_q;
        `STC_OFF_X_HI: rdata_d = {4'h0, x_q[11:8]};
        `STC_OFF_X_LO: rdata_d = x_q[7:0];
        `STC_OFF_Y_HI: rdata_d = {4'h0, y_q[11:8]};
        `STC_OFF_Y_LO: rdata_d = y_q[7:0];
        default: rdata_d = `STC_UNMAPPED_READ;
      endcase
    end
  end

  // read data registered: answer one cycle after the strobe, held
  // until the next read so the serial shifter may take it at leisure
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      rdata_q <= `STC_REG_RESET;
    end else if (req_in.rd) begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req_in.rd;
    end
  end

  assign rdata_out = rdata_q;
  assign rvalid_out = rvalid_q;

  // checks on the bank's behaviour
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // helper copies of the assembled thresholds
  logic [CODE_W-1:0] second_auxiliary_input_max_thr;
  logic [CODE_W-1:0] second_auxiliary_input_min_thr;
  logic [CODE_W-1:0] temp_max_thr;
  logic [CODE_W-1:0] temp_min_thr;
  assign second_auxiliary_input_max_thr = {thr_q[0][3:0], thr_q[1]};
  assign second_auxiliary_input_min_thr = {thr_q[2][3:0], thr_q[3]};
  assign temp_max_thr = {thr_q[4][3:0], thr_q[5]};
  assign temp_min_thr = {thr_q[6][3:0], thr_q[7]};

  a_second_auxiliary_input_max_set: assert property (
    (is_second_auxiliary_input && thr_q[0][4] && (result_in.code >= second_auxiliary_input_max_thr))
    |=> flags_out[3]
  ) else $error("second_auxiliary_input max flag not set");

  a_second_auxiliary_input_max_gate: assert property (
    $rose(flags_out[3]) |->
    $past(is_second_auxiliary_input && thr_q[0][4] && (result_in.code >= second_auxiliary_input_max_thr))
  ) else $error("second_auxiliary_input max flag set without cause");

  a_second_auxiliary_input_min_set: assert property (
    (is_second_auxiliary_input && thr_q[2][4] && (result_in.code <= second_auxiliary_input_min_thr))
    |=> flags_out[2]
  ) else $error("second_auxiliary_input min flag not set");

  a_second_auxiliary_input_min_gate: assert property (
    $rose(flags_out[2]) |->
    $past(is_second_auxiliary_input && thr_q[2][4] && (result_in.code <= second_auxiliary_input_min_thr))
  ) else $error("second_auxiliary_input min flag set without cause");

  a_temp_max_set: assert property (
    (is_temp && thr_q[4][4] && (result_in.code >= temp_max_thr))
    |=> flags_out[1]
  ) else $error("temp max flag not set");

  a_temp_max_gate: assert property (
    $rose(flags_out[1]) |->
    $past(is_temp && thr_q[4][4] && (result_in.code >= temp_max_thr))
  ) else $error("temp max flag set without cause");

  a_temp_min_set: assert property (
    (is_temp && thr_q[6][4] && (result_in.code <= temp_min_thr))
    |=> flags_out[0]
  ) else $error("temp min flag not set");

  a_temp_min_gate: assert property (
    $rose(flags_out[0]) |->
    $past(is_temp && thr_q[6][4] && (result_in.code <= temp_min_thr))
  ) else $error("temp min flag set without cause");

  a_flag_clear: assert property (
    (flag_read_in && (hit == '0)) |=> (flags_out == '0)
  ) else $error("flags not cleared by read");

  a_flag_sticky: assert property (
    (!flag_read_in && (flags_out != '0)) |=>
    ((flags_out & $past(flags_out)) == $past(flags_out))
  ) else $error("sticky flag dropped");

  a_first_auxiliary_input_write: assert property (
    (req_in.wr && (req_in.addr == 7'h19)) |=>
    (first_auxiliary_input_min_low_out == $past(req_in.wdata))
  ) else $error("first_auxiliary_input min low byte not written");

  a_coord_pair: assert property (
    (coord_in.valid && !req_in.rd) ##1
    (req_in.rd && (req_in.addr == 7'h2D)) |=>
    (rdata_out == $past(coord_in.y[7:0], 2)) && rvalid_out
  ) else $error("y low byte from wrong conversion");

  a_x_high_read: assert property (
    (req_in.rd && (req_in.addr == 7'h2A)) |=>
    (rdata_out == {4'h0, $past(x_q[11:8])})
  ) else $error("x high byte read wrong");

  a_rsvd_read: assert property (
    (req_in.rd && in_rsvd) |=> (rdata_out == 8'h00) ##1 1'b1
  ) else $error("reserved offset read not zero");

  a_x_read_only: assert property (
    (req_in.wr && !coord_in.valid) |=> (x_q == $past(x_q))
  ) else $error("x result changed by a write");

  a_rdata_hold: assert property (
    (!req_in.rd [*2]) |-> $stable(rdata_out)
  ) else $error("read data moved without a read");

  a_x_low_read: assert property (
    (req_in.rd && (req_in.addr == 7'h2B)) |=>
    (rdata_out == $past(x_q[7:0]))
  ) else $error("x low byte read wrong");

  a_y_high_read: assert property (
    (req_in.rd && (req_in.addr == 7'h2C)) |=>
    (rdata_out == {4'h0, $past(y_q[11:8])})
  ) else $error("y high byte read wrong");

  a_y_low_read: assert property (
    (req_in.rd && (req_in.addr == 7'h2D)) |=>
    (rdata_out == $past(y_q[7:0]))
  ) else $error("y low byte read wrong");

  a_bank_write: assert property (
    (req_in.wr && in_bank) |=>
    (thr_q[$past(bank_idx)] == $past(req_in.wdata))
  ) else $error("threshold byte not written");

  // a flag can only rise after a cycle in which its check was enabled
  a_second_auxiliary_input_max_off: assert property (
    !thr_q[0][4] |=>
    !$rose(flags_out[3])
  ) else $error("disabled second_auxiliary_input max check set its flag");

  a_second_auxiliary_input_min_off: assert property (
    !thr_q[2][4] |=>
    !$rose(flags_out[2])
  ) else $error("disabled second_auxiliary_input min check set its flag");

  a_temp_max_off: assert property (
    !thr_q[4][4] |=>
    !$rose(flags_out[1])
  ) else $error("disabled temp max check set its flag");

  a_temp_min_off: assert property (
    !thr_q[6][4] |=>
    !$rose(flags_out[0])
  ) else $error("disabled temp min check set its flag");

  a_read_answer: assert property (
    req_in.rd |=>
    rvalid_out
  ) else $error("read not answered next cycle");

  a_rvalid_pulse: assert property (
    !req_in.rd |=>
    !rvalid_out
  ) else $error("read valid without a read");

endmodule : stc_regs
`default_nettype wire

/* testbench/stc_host_model.sv */
// host model driving register requests over the control port
`include "stc_defines.svh"
`default_nettype none
module stc_host_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  output var stc_pkg::stc_req_s req_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idle at time zero
  initial begin
    req_out = '0;
  end

  // one write; clears bits 7:5 of the temperature high bytes and zeroes reserved writes
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == `STC_OFF_TEMP_MAX_HI || a == `STC_OFF_TEMP_MIN_HI) begin
      v[7:5] = 3'h0;
    end
    if (a >= `STC_OFF_RSVD_FIRST && a <= `STC_OFF_RSVD_LAST) begin
      v = 8'h00;
    end
    @(posedge sys_clk_in);
    req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge sys_clk_in);
    // released lines move so stale values cannot pass
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
  endtask : wr

  // one read; answer sampled once the taking edge has landed
  task automatic rd(input logic [6:0] a, output logic [7:0] d,
                    output logic ok);
    @(posedge sys_clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
    @(posedge sys_clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
    #1;
    ok = rvalid_in;
    d = rdata_in;
  endtask : rd
endmodule : stc_host_model
`default_nettype wire

/* testbench/stc_regs_tb_top.sv */
// self-checking bench for the threshold and coordinate register bank
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))
module stc_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  stc_pkg::stc_req_s req_in;
  stc_pkg::stc_result_s result_in = '0;
  stc_pkg::stc_coord_s coord_in = '0;
  logic flag_read_in = 1'b0;
  logic [7:0] rdata_out;
  logic rvalid_out;
  logic [3:0] flags_out;
  logic [7:0] first_auxiliary_input_min_low_out;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;

  // 100 MHz clock
  always #5 sys_clk_in = ~sys_clk_in;

  stc_regs uut (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .req_in(req_in),
    .result_in(result_in), .coord_in(coord_in),
    .flag_read_in(flag_read_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .flags_out(flags_out),
    .first_auxiliary_input_min_low_out(first_auxiliary_input_min_low_out)
  );

  stc_host_model host (
    .sys_clk_in(sys_clk_in), .rdata_in(rdata_out),
    .rvalid_in(rvalid_out), .req_out(req_in)
  );

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check_val

  // read one register, expect a one-cycle answer with value e
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    `CHK(ok, 1'b1);
    `CHK(d, e);
  endtask : rchk

  // all mapped and reserved bytes, and unmapped offset 7F, read zero after reset
  task automatic t_reset();
    for (int i = 'h19; i <= 'h2D; i++) begin
      rchk(7'(i), 8'h00);
    end
    rchk(7'h7F, 8'h00);
    `CHK(first_auxiliary_input_min_low_out, 8'h00);
  endtask : t_reset

  // threshold bytes read back; read-only and reserved places hold zero
  task automatic t_rw();
    logic [7:0] wv [9] = '{8'hA5, 8'hE7, 8'h5C, 8'hE3, 8'h3A, 8'hEF,
                           8'h77, 8'hE6, 8'h88};
    logic [7:0] ev [9] = '{8'hA5, 8'hE7, 8'h5C, 8'hE3, 8'h3A, 8'h0F,
                           8'h77, 8'h06, 8'h88};
    for (int i = 0; i < 9; i++) begin
      host.wr(7'(8'h19 + i), wv[i]);
    end
    for (int i = 0; i < 9; i++) begin
      rchk(7'(8'h19 + i), ev[i]);
    end
    `CHK(first_auxiliary_input_min_low_out, 8'hA5);
    host.wr(7'h2A, 8'h55);
    host.wr(7'h22, 8'h55);
    rchk(7'h2A, 8'h00);
    rchk(7'h22, 8'h00);
  endtask : t_rw

  task automatic send(input stc_pkg::stc_src_e s, input logic [11:0] c);
    @(posedge sys_clk_in);
    result_in <= '{valid: 1'b1, src: s, code: c};
    @(posedge sys_clk_in);
    result_in <= '{valid: 1'b0, src: s, code: ~c};
    @(posedge sys_clk_in);
    #1;
  endtask : send

  // one check: disabled, just short of the boundary, on it, sticky, cleared
  task automatic do_check(input logic [6:0] a, input logic [11:0] thr,
                          input logic mx, input stc_pkg::stc_src_e s,
                          input int b);
    logic [3:0] e;
    e = 4'h0;
    e[b] = 1'b1;
    host.wr(a, {4'h0, thr[11:8]});
    host.wr(a + 7'h01, thr[7:0]);
    send(s, thr);
    `CHK(flags_out, 4'h0);
    host.wr(a, {4'h1, thr[11:8]});
    send(s, mx ? thr - 12'h001 : thr + 12'h001);
    `CHK(flags_out, 4'h0);
    send(s, thr);
    `CHK(flags_out, e);
    send(s, mx ? thr - 12'h001 : thr + 12'h001);
    `CHK(flags_out, e);
    @(posedge sys_clk_in);
    flag_read_in <= 1'b1;
    @(posedge sys_clk_in);
    flag_read_in <= 1'b0;
    @(posedge sys_clk_in);
    #1;
    `CHK(flags_out, 4'h0);
    host.wr(a, 8'h00);
  endtask : do_check

  // two captures back to back; reads give the latest pair
  task automatic t_coord();
    @(posedge sys_clk_in);
    coord_in <= '{valid: 1'b1, x: 12'h5F0, y: 12'h70E};
    @(posedge sys_clk_in);
    coord_in <= '{valid: 1'b1, x: 12'hABC, y: 12'h123};
    // first read lands right behind the last capture
    fork
      begin
        @(posedge sys_clk_in);
        coord_in <= '{valid: 1'b0, x: 12'h543, y: 12'hEDC};
      end
      rchk(7'h2D, 8'h23);
    join
    rchk(7'h2A, 8'h0A);
    rchk(7'h2B, 8'hBC);
    rchk(7'h2C, 8'h01);
  endtask : t_coord

  // cut a hang short
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      complete_run();
    end
  end

  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_rw();
    do_check(7'h1A, 12'h800, 1'b1, stc_pkg::STC_SRC_SECOND_AUXILIARY_INPUT, 3);
    do_check(7'h1C, 12'h2A5, 1'b0, stc_pkg::STC_SRC_SECOND_AUXILIARY_INPUT, 2);
    do_check(7'h1E, 12'hFFF, 1'b1, stc_pkg::STC_SRC_TEMPERATURE_METHOD_ONE, 1);
    do_check(7'h20, 12'h000, 1'b0, stc_pkg::STC_SRC_TEMPERATURE_METHOD_TWO, 0);
    t_coord();
    complete_run();
  end
endmodule : stc_regs_tb_top
`default_nettype wire
